// [logic/oatm_params.svh]
`ifndef OATM_PARAMS_SVH
`define OATM_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define OATM_ADDR_W 4
`define OATM_CFG_OFS 4'h0
`define OATM_STAT_OFS 4'h4
`define OATM_CFG_RESET 32'h0000_0506

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define OATM_CFG_PD_BIT 0
`define OATM_CFG_NOM_BIT 1
`define OATM_CFG_WR_BIT 2
`define OATM_CFG_AL_LSB 4
`define OATM_CFG_CWL_LSB 8

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define OATM_CLK_PERIOD_PS 50000
`define OATM_ASYNC_MIN_PS 2000
`define OATM_ASYNC_MAX_PS 8500
`define OATM_ASYNC_MIN_CYC ((`OATM_ASYNC_MIN_PS + `OATM_CLK_PERIOD_PS - 1) / `OATM_CLK_PERIOD_PS)
`define OATM_ASYNC_MAX_RAW (`OATM_ASYNC_MAX_PS / `OATM_CLK_PERIOD_PS)
`define OATM_ASYNC_MAX_CYC ((`OATM_ASYNC_MAX_RAW < 1) ? 1 : `OATM_ASYNC_MAX_RAW)
`define OATM_SYNC_LAT_OFS 2
`define OATM_ANPD_OFS 1
`define OATM_RELOCK_CYC 24
`define OATM_REFRESH_CYC 8
`define OATM_HIST_DEPTH 32

`endif

// [logic/oatm_pkg.sv]
package oatm_pkg;

    typedef enum logic [1:0] {
        OATM_SYNC  = 2'b00,
        OATM_ASYNC = 2'b01,
        OATM_EXIT  = 2'b11
    } oatm_mode_t;

    typedef struct packed {
        logic [3:0] write_cas_latency;
        logic [3:0] additive_latency;
        logic write_termination;
        logic nominal_termination;
        logic loop_powerdown_control_bit;
    } oatm_cfg_t;

    typedef struct packed {
        logic relocking;
        logic term_on;
        logic powerdown_exit_window;
        logic powerdown_entry_window;
        logic async_mode;
    } oatm_status_t;

endpackage

// [logic/oatm_odt_async.sv]
// Function
// - Use asynchronous termination in precharge power-down with loop off and termination enabled.
// - Use asynchronous termination while the delay-locked loop relocks after reset.
// - Asynchronous mode ignores additive latency; the input acts directly.
// - Asynchronous delays replace the clock-counted latencies and their tolerances.
// - Turn-on starts no sooner than 2 ns, complete by 8.5 ns after sampling; the logic turns on one 50 ns clock after the synchronised pin.
// - Turn-off starts no sooner than 2 ns, complete by 8.5 ns after sampling; the logic turns off one 50 ns clock after the synchronised pin.
// - Transition windows exist only when the loop-control mode bit is 0.
// - Entry window spans one transition interval before clock enable registered low.
// - Transition interval equals write latency minus one clock.
// - A running refresh stretches the entry window to one refresh cycle time.
// - Turn-on inside entry window lies between lesser minimum and greater maximum.
// - Turn-off inside entry window lies between lesser minimum and greater maximum.
// - After the entry window, respond with asynchronous timing only.
// - Exit window spans transition interval plus relock exit time around clock enable high.
// - Changes inside the exit window may use either timing.
// - After the exit window, respond with synchronous clock-counted timing.
// - Short clock-enable low pulse: either timing from entry start to exit end.
// - Short clock-enable high pulse: either timing from exit start to entry end.
// - Synchronous latencies equal write latency plus additive latency minus two clocks.
//
// The implementer's own choices: strobed register access and the address map.
`include "oatm_params.svh"

module oatm_odt_async
    import oatm_pkg::*;
#(
    parameter int unsigned RELOCK_CYC = `OATM_RELOCK_CYC,
    parameter int unsigned REFRESH_CYC = `OATM_REFRESH_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic odt_pin,
    input wire logic cke_pin,
    input wire logic refresh_cmd_pin,
    input wire logic loop_relocking,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic term_on_ff
);

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic odt_s;
    logic cke_s;
    logic ref_s;

    // Clock enable resets to its idle high level; a low reset value would look like
    // power-down entry on the first edges after release.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= 3'h2;
            sync2_ff <= 3'h2;
        end else if (ce) begin
            sync1_ff <= {refresh_cmd_pin, cke_pin, odt_pin};
            sync2_ff <= sync1_ff;
        end
    end

    assign odt_s = sync2_ff[0];
    assign cke_s = sync2_ff[1];
    assign ref_s = sync2_ff[2];

    // ------------------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------------------
    oatm_cfg_t cfg_ff;
    logic term_en;
    logic [5:0] sync_lat;
    logic [5:0] anpd_cyc;
    // The reset word is unpacked by field position, the same layout that a write uses.
    localparam logic [31:0] CFG_RESET = `OATM_CFG_RESET;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ff.loop_powerdown_control_bit <= CFG_RESET[`OATM_CFG_PD_BIT];
            cfg_ff.nominal_termination <= CFG_RESET[`OATM_CFG_NOM_BIT];
            cfg_ff.write_termination <= CFG_RESET[`OATM_CFG_WR_BIT];
            cfg_ff.additive_latency <= CFG_RESET[`OATM_CFG_AL_LSB +: 4];
            cfg_ff.write_cas_latency <= CFG_RESET[`OATM_CFG_CWL_LSB +: 4];
        end else if (ce && reg_wr && reg_addr == `OATM_CFG_OFS) begin
            cfg_ff.loop_powerdown_control_bit <= reg_wdata[`OATM_CFG_PD_BIT];
            cfg_ff.nominal_termination <= reg_wdata[`OATM_CFG_NOM_BIT];
            cfg_ff.write_termination <= reg_wdata[`OATM_CFG_WR_BIT];
            cfg_ff.additive_latency <= reg_wdata[`OATM_CFG_AL_LSB +: 4];
            cfg_ff.write_cas_latency <= reg_wdata[`OATM_CFG_CWL_LSB +: 4];
        end
    end

    assign term_en = cfg_ff.nominal_termination | cfg_ff.write_termination;
    // Latency is only meaningful for write latency of three or more clocks.
    assign sync_lat = 6'({2'h0, cfg_ff.write_cas_latency} + {2'h0, cfg_ff.additive_latency}
                         - 6'(`OATM_SYNC_LAT_OFS));
    assign anpd_cyc = 6'(sync_lat + 6'(`OATM_ANPD_OFS));

    // ------------------------------------------------------------------------
    // Refresh in progress
    // ------------------------------------------------------------------------
    logic [15:0] ref_cnt_ff;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_cnt_ff <= 16'h0000;
        end else if (ce) begin
            if (ref_s) begin
                ref_cnt_ff <= 16'(REFRESH_CYC);
            end else if (ref_cnt_ff != 16'h0000) begin
                ref_cnt_ff <= ref_cnt_ff - 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Mode sequencing
    // ------------------------------------------------------------------------
    // The entry window opens before clock enable falls, which the device cannot
    // foresee; inside it either timing is legal, so the device stays
    // synchronous until the window has closed.
    oatm_mode_t mode_ff;
    logic [15:0] exit_cnt_ff;
    logic use_async;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= OATM_SYNC;
            exit_cnt_ff <= 16'h0000;
        end else if (ce) begin
            unique case (mode_ff)
                OATM_SYNC: begin
                    // A refresh strobe seen on this very edge already counts as running.
                    if (!cke_s && !cfg_ff.loop_powerdown_control_bit && ref_cnt_ff == 16'h0000 && !ref_s) begin
                        mode_ff <= OATM_ASYNC;
                    end
                end
                OATM_ASYNC: begin
                    if (cke_s) begin
                        mode_ff <= OATM_EXIT;
                        exit_cnt_ff <= 16'(RELOCK_CYC);
                    end
                end
                OATM_EXIT: begin
                    if (!cke_s) begin
                        mode_ff <= OATM_ASYNC;
                    end else if (exit_cnt_ff <= 16'h0001) begin
                        mode_ff <= OATM_SYNC;
                        exit_cnt_ff <= 16'h0000;
                    end else begin
                        exit_cnt_ff <= exit_cnt_ff - 16'h0001;
                    end
                end
                default: begin
                    mode_ff <= OATM_SYNC;
                end
            endcase
        end
    end

    assign use_async = (mode_ff != OATM_SYNC) | loop_relocking;

    // ------------------------------------------------------------------------
    // Termination control
    // ------------------------------------------------------------------------
    // The history keeps shifting in every mode so that the synchronous path
    // sees valid samples the moment the exit window closes.
    logic [`OATM_HIST_DEPTH-1:0] hist_ff;
    logic sync_val;
    logic nxt_term;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hist_ff <= '0;
        end else if (ce) begin
            hist_ff <= {hist_ff[`OATM_HIST_DEPTH-2:0], odt_s};
        end
    end

    always_comb begin
        if (sync_lat <= 6'h01) begin
            sync_val = odt_s;
        end else begin
            sync_val = hist_ff[5'(sync_lat - 6'h02)];
        end
        if (!term_en) begin
            nxt_term = 1'b0;
        end else if (use_async) begin
            // One clock of 50 ns is the only whole-cycle delay in range.
            nxt_term = odt_s;
        end else begin
            nxt_term = sync_val;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            term_on_ff <= 1'b0;
        end else if (ce) begin
            term_on_ff <= nxt_term;
        end
    end

    // ------------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------------
    oatm_status_t status;

    always_comb begin
        status.async_mode = use_async;
        status.powerdown_entry_window = (mode_ff == OATM_SYNC) && !cke_s
                                        && !cfg_ff.loop_powerdown_control_bit;
        status.powerdown_exit_window = (mode_ff == OATM_EXIT);
        status.term_on = term_on_ff;
        status.relocking = loop_relocking;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (ce) begin
            if (reg_rd && reg_addr == `OATM_CFG_OFS) begin
                reg_rdata <= {20'h0, cfg_ff.write_cas_latency, cfg_ff.additive_latency, 1'b0,
                              cfg_ff.write_termination, cfg_ff.nominal_termination,
                              cfg_ff.loop_powerdown_control_bit};
            end else if (reg_rd && reg_addr == `OATM_STAT_OFS) begin
                reg_rdata <= {27'h0, status};
            end else begin
                reg_rdata <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    // Delays are checked at the one-clock granularity that the logic uses; the finer
    // analog bounds cannot be resolved on this clock.
    property p_term_disabled;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && !term_en) |=> !term_on_ff;
    endproperty
    a_term_disabled: assert property (p_term_disabled) else $error("termination on while disabled");

    property p_relock_async;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && loop_relocking && term_en) |=> term_on_ff == $past(odt_s);
    endproperty
    a_relock_async: assert property (p_relock_async) else $error("relock not asynchronous");

    property p_async_on;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && use_async && term_en && odt_s) |=> term_on_ff;
    endproperty
    a_async_on: assert property (p_async_on) else $error("async turn-on missed one clock");

    property p_async_off;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && use_async && !odt_s) |=> !term_on_ff;
    endproperty
    a_async_off: assert property (p_async_off) else $error("async turn-off missed one clock");

    property p_dll_on_stays_sync;
        @(posedge ref_clk) disable iff (!rst_n)
        (mode_ff == OATM_SYNC && cfg_ff.loop_powerdown_control_bit) |=> mode_ff == OATM_SYNC;
    endproperty
    a_dll_on_stays_sync: assert property (p_dll_on_stays_sync) else $error("window with loop kept on");

    property p_entry_close;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && mode_ff == OATM_SYNC && !cke_s && !cfg_ff.loop_powerdown_control_bit
         && ref_cnt_ff == 16'h0000 && !ref_s) |=> mode_ff == OATM_ASYNC;
    endproperty
    a_entry_close: assert property (p_entry_close) else $error("entry did not go asynchronous");

    property p_refresh_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        (mode_ff == OATM_SYNC && ref_cnt_ff != 16'h0000) |=> mode_ff == OATM_SYNC;
    endproperty
    a_refresh_hold: assert property (p_refresh_hold) else $error("entry closed during refresh");

    property p_exit_load;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && mode_ff == OATM_ASYNC && cke_s) |=> (mode_ff == OATM_EXIT && exit_cnt_ff == 16'(RELOCK_CYC));
    endproperty
    a_exit_load: assert property (p_exit_load) else $error("exit window not started");

    property p_exit_done;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && mode_ff == OATM_EXIT && cke_s && exit_cnt_ff == 16'h0001) |=> mode_ff == OATM_SYNC;
    endproperty
    a_exit_done: assert property (p_exit_done) else $error("exit window did not close");

    // The transition interval is one clock longer than the synchronous latency.
    property p_anpd_value;
        @(posedge ref_clk) disable iff (!rst_n)
        anpd_cyc == 6'({2'h0, cfg_ff.write_cas_latency} + {2'h0, cfg_ff.additive_latency} - 6'h01);
    endproperty
    a_anpd_value: assert property (p_anpd_value) else $error("interval not latency plus one");

    property p_async_follow;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && mode_ff != OATM_SYNC && term_en) |=> term_on_ff == $past(odt_s);
    endproperty
    a_async_follow: assert property (p_async_follow) else $error("power-down output not direct");

    property p_exit_count;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && mode_ff == OATM_EXIT && cke_s && exit_cnt_ff > 16'h0001)
        |=> (mode_ff == OATM_EXIT && exit_cnt_ff == $past(exit_cnt_ff) - 16'h0001);
    endproperty
    a_exit_count: assert property (p_exit_count) else $error("exit window miscounted");

    property p_exit_whole;
        @(posedge ref_clk) disable iff (!rst_n)
        (mode_ff == OATM_EXIT && exit_cnt_ff > 16'h0001) |=> mode_ff != OATM_SYNC;
    endproperty
    a_exit_whole: assert property (p_exit_whole) else $error("exit window cut short");

    property p_short_high;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && mode_ff == OATM_EXIT && !cke_s) |=> mode_ff == OATM_ASYNC;
    endproperty
    a_short_high: assert property (p_short_high) else $error("short high pulse not re-entered");

    property p_sync_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && mode_ff == OATM_SYNC && cke_s) |=> mode_ff == OATM_SYNC;
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("entry without clock enable low");

    property p_async_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && mode_ff == OATM_ASYNC && !cke_s) |=> mode_ff == OATM_ASYNC;
    endproperty
    a_async_hold: assert property (p_async_hold) else $error("left power-down while clock enable low");

    property p_no_exit_from_sync;
        @(posedge ref_clk) disable iff (!rst_n)
        (mode_ff == OATM_SYNC) |=> mode_ff != OATM_EXIT;
    endproperty
    a_no_exit_from_sync: assert property (p_no_exit_from_sync) else $error("exit window without power-down");

    property p_refresh_load;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && ref_s) |=> ref_cnt_ff == 16'(REFRESH_CYC);
    endproperty
    a_refresh_load: assert property (p_refresh_load) else $error("refresh time not loaded");

    property p_refresh_count;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && !ref_s && ref_cnt_ff != 16'h0000) |=> ref_cnt_ff == $past(ref_cnt_ff) - 16'h0001;
    endproperty
    a_refresh_count: assert property (p_refresh_count) else $error("refresh time miscounted");

    // A low clock enable stands for a stopped clock, so no counter and no output may move.
    property p_freeze;
        @(posedge ref_clk) disable iff (!rst_n)
        !ce |=> ($stable(term_on_ff) && $stable(mode_ff) && $stable(exit_cnt_ff)
                 && $stable(ref_cnt_ff) && $stable(reg_rdata));
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

    c_entry: cover property (@(posedge ref_clk) disable iff (!rst_n)
        mode_ff == OATM_SYNC ##1 mode_ff == OATM_ASYNC);
    c_exit: cover property (@(posedge ref_clk) disable iff (!rst_n)
        mode_ff == OATM_EXIT ##1 mode_ff == OATM_SYNC);
    c_short_high: cover property (@(posedge ref_clk) disable iff (!rst_n)
        mode_ff == OATM_EXIT ##1 mode_ff == OATM_ASYNC);
    c_refresh_hold: cover property (@(posedge ref_clk) disable iff (!rst_n)
        mode_ff == OATM_SYNC && ref_cnt_ff != 16'h0000 && !cke_s);
    c_relock_on: cover property (@(posedge ref_clk) disable iff (!rst_n)
        loop_relocking && term_on_ff);

endmodule

// [verif/oatm_ctrl_model.sv]
module oatm_ctrl_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic odt_req,
    input wire logic cke_req,
    input wire logic refresh_req,
    output logic odt_pin,
    output logic cke_pin,
    output logic refresh_cmd_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] late_ff;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            late_ff <= 3'h2;
        end else begin
            late_ff <= {refresh_req, cke_req, odt_req};
        end
    end

    // A slow controller launches every pin one cycle late, so the device must not rely on a fixed phase.
    assign {refresh_cmd_pin, cke_pin, odt_pin} = slow ? late_ff : {refresh_req, cke_req, odt_req};
endmodule

// [verif/tb_odt_async_mode_transition.sv]
module tb_odt_async_mode_transition;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int SYNC_N = 2 + 5 + 2 - 2;
    localparam int ASYNC_N = 3;

    logic ref_clk, rst_n, ce, slow, odt_req, cke_req, refresh_req, loop_relocking, reg_wr, reg_rd;
    logic odt_pin, cke_pin, refresh_cmd_pin, term_on_ff;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd;
    int num_errors = 0;
    int check_count = 0;

    oatm_odt_async #(.RELOCK_CYC(4), .REFRESH_CYC(6)) i_oatm_odt_async (
        .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .odt_pin(odt_pin), .cke_pin(cke_pin),
        .refresh_cmd_pin(refresh_cmd_pin), .loop_relocking(loop_relocking), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .term_on_ff(term_on_ff));

    oatm_ctrl_model i_oatm_ctrl_model (
        .ref_clk(ref_clk), .rst_n(rst_n), .slow(slow), .odt_req(odt_req), .cke_req(cke_req),
        .refresh_req(refresh_req), .odt_pin(odt_pin), .cke_pin(cke_pin), .refresh_cmd_pin(refresh_cmd_pin));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        if (num_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Counts edges from the request launch until the termination output follows it.
    task automatic odt_delay(input string name, input logic v, input int exp);
        int n;
        n = 0;
        @(posedge ref_clk);
        odt_req <= v;
        do begin
            @(posedge ref_clk);
            #1 n++;
        end while (term_on_ff !== v && n < 40);
        check(name, n, exp);
    endtask

    task automatic t_regs();
        rd_reg(4'h0); check("cfg reset", rd, 32'h0000_0506);
        rd_reg(4'h4); check("status reset", rd, 32'h0000_0000);
        rd_reg(4'h8); check("unmapped read", rd, 32'h0000_0000);
        wr(4'h4, 32'h0000_00FF);
        rd_reg(4'h4); check("status read only", rd, 32'h0000_0000);
        wr(4'h0, 32'h0000_0526);
        rd_reg(4'h0); check("cfg write", rd, 32'h0000_0526);
    endtask

    task automatic t_sync();
        odt_delay("sync on", 1'b1, SYNC_N);
        odt_delay("sync off", 1'b0, SYNC_N);
    endtask

    task automatic t_pd_cycle();
        @(posedge ref_clk);
        cke_req <= 1'b0;
        wait_cyc(6);
        rd_reg(4'h4); check("pd async", rd, 32'h0000_0001);
        odt_delay("async on", 1'b1, ASYNC_N);
        odt_delay("async off", 1'b0, ASYNC_N);
        odt_delay("async on late", 1'b1, ASYNC_N);
        odt_delay("async off late", 1'b0, ASYNC_N);
        cke_req <= 1'b1;
        wait_cyc(3);
        rd_reg(4'h4); check("exit window", rd & 32'h0000_0004, 32'h0000_0004);
        wait_cyc(8);
        rd_reg(4'h4); check("back to sync", rd, 32'h0000_0000);
        odt_delay("post exit on", 1'b1, SYNC_N);
        odt_delay("post exit off", 1'b0, SYNC_N);
    endtask

    task automatic t_loop_on();
        wr(4'h0, 32'h0000_0527);
        cke_req <= 1'b0;
        wait_cyc(6);
        rd_reg(4'h4); check("loop on stays sync", rd, 32'h0000_0000);
        odt_delay("loop on sync on", 1'b1, SYNC_N);
        odt_delay("loop on sync off", 1'b0, SYNC_N);
        cke_req <= 1'b1;
        wr(4'h0, 32'h0000_0526);
        wait_cyc(10);
    endtask

    task automatic t_relock();
        loop_relocking <= 1'b1;
        wait_cyc(2);
        rd_reg(4'h4); check("relock status", rd, 32'h0000_0011);
        odt_delay("relock on", 1'b1, ASYNC_N);
        slow <= 1'b1;
        odt_delay("relock off slow", 1'b0, ASYNC_N + 1);
        slow <= 1'b0;
        loop_relocking <= 1'b0;
        wait_cyc(4);
    endtask

    task automatic t_refresh();
        @(posedge ref_clk);
        refresh_req <= 1'b1;
        cke_req <= 1'b0;
        @(posedge ref_clk);
        refresh_req <= 1'b0;
        wait_cyc(1);
        rd_reg(4'h4); check("entry held by refresh", rd & 32'h0000_0003, 32'h0000_0002);
        wait_cyc(12);
        rd_reg(4'h4); check("async after refresh", rd & 32'h0000_0001, 32'h0000_0001);
        cke_req <= 1'b1;
        wait_cyc(15);
    endtask

    task automatic t_short_cke();
        @(posedge ref_clk);
        cke_req <= 1'b0;
        @(posedge ref_clk);
        cke_req <= 1'b1;
        wait_cyc(20);
        rd_reg(4'h4); check("short pulse settles", rd, 32'h0000_0000);
        odt_delay("short pulse sync", 1'b1, SYNC_N);
        odt_delay("short pulse sync off", 1'b0, SYNC_N);
    endtask

    task automatic t_no_term();
        wr(4'h0, 32'h0000_0520);
        @(posedge ref_clk);
        odt_req <= 1'b1;
        wait_cyc(10);
        check("no termination", term_on_ff, 1'b0);
        odt_req <= 1'b0;
        wr(4'h0, 32'h0000_0526);
    endtask

    task automatic t_short_high();
        @(posedge ref_clk);
        cke_req <= 1'b0;
        wait_cyc(6);
        cke_req <= 1'b1;
        @(posedge ref_clk);
        cke_req <= 1'b0;
        wait_cyc(6);
        rd_reg(4'h4); check("short high back to async", rd, 32'h0000_0001);
        cke_req <= 1'b1;
        wait_cyc(15);
    endtask

    task automatic t_freeze();
        @(posedge ref_clk);
        odt_req <= 1'b1;
        wait_cyc(10);
        #1 check("freeze before", term_on_ff, 32'h0000_0001);
        @(posedge ref_clk);
        ce <= 1'b0;
        odt_req <= 1'b0;
        wait_cyc(10);
        #1 check("freeze holds", term_on_ff, 32'h0000_0001);
        @(posedge ref_clk);
        ce <= 1'b1;
        wait_cyc(10);
        #1 check("freeze released", term_on_ff, 32'h0000_0000);
    endtask

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        slow = 1'b0;
        odt_req = 1'b0;
        cke_req = 1'b1;
        refresh_req = 1'b0;
        loop_relocking = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0000_0000;
        wait_cyc(5);
        rst_n <= 1'b1;
        t_regs();
        t_sync();
        t_pd_cycle();
        t_loop_on();
        t_relock();
        t_refresh();
        t_short_cke();
        t_short_high();
        t_no_term();
        t_freeze();
        conclude();
    end

    // Whole run needs well under a thousand cycles; three thousand leaves ample margin.
    initial begin
        #(3000 * 50);
        num_errors++;
        conclude();
    end
endmodule
